// >>> common/cfgfw_pkg.sv
package cfgfw_pkg;

    // Table address space
    localparam logic [15:0] CFG_ADDR_BASE   = 16'hfe00;
    localparam logic [15:0] CFG_ADDR_HIGH   = 16'hfe08;
    localparam logic [15:0] CFG_ADDR_LAST   = 16'hfe0f;
    localparam logic [7:0]  LATCH_ALL_ONES  = 8'hff;

    // Fuse index (low nibble of the table address) per fuse bit
    localparam logic [3:0]  IDX_OSC_LO      = 4'h0;
    localparam logic [3:0]  IDX_OSC_HI      = 4'h1;
    localparam logic [3:0]  IDX_WDT_LO      = 4'h2;
    localparam logic [3:0]  IDX_WDT_HI      = 4'h3;
    localparam logic [3:0]  IDX_PM0         = 4'h4;
    localparam logic [3:0]  IDX_PM1         = 4'h6;
    localparam logic [3:0]  IDX_BOD         = 4'he;
    localparam logic [3:0]  IDX_PM2         = 4'hf;

    // Bit position of each fuse in the 16-bit configuration word
    localparam int POS_OSC_LO = 0;
    localparam int POS_OSC_HI = 1;
    localparam int POS_WDT_LO = 2;
    localparam int POS_WDT_HI = 3;
    localparam int POS_PM0    = 4;
    localparam int POS_PM1    = 6;
    localparam int POS_BOD    = 14;
    localparam int POS_PM2    = 15;

    // Unprogrammed fuse state
    localparam logic [7:0]  FUSE_RESET      = 8'hff;

    // Timers
    localparam int CLK_HZ          = 10_000_000;
    localparam int POWERUP_DELAY_TIMER_MS         = 96;
    localparam int POWERUP_DELAY_TIMER_CYCLES     = CLK_HZ / 1000 * POWERUP_DELAY_TIMER_MS;
    localparam int OST_TOSC        = 1024;
    localparam int OST_CYCLES      = OST_TOSC;

    // Processor mode encodings
    localparam logic [2:0] PM_MICROPROC = 3'h7;
    localparam logic [2:0] PM_MICROCTL  = 3'h6;
    localparam logic [2:0] PM_EXTMCU    = 3'h5;
    localparam logic [2:0] PM_PROTECTED = 3'h0;

    typedef enum logic [1:0] {
        CFGFW_LOW_POWER_CRYSTAL_MODE,
        CFGFW_RC_MODE,
        CFGFW_CRYSTAL_RESONATOR_MODE,
        CFGFW_EXTERNAL_CLOCK_MODE
    } cfgfw_osc_t;

    typedef enum logic [2:0] {
        CFGFW_MICROPROCESSOR,
        CFGFW_MICROCONTROLLER,
        CFGFW_EXT_MICROCONTROLLER,
        CFGFW_PROTECTED_MCU,
        CFGFW_MODE_UNDEFINED
    } cfgfw_mode_t;

    // Decoded settings
    typedef struct packed {
        cfgfw_mode_t mode;
        cfgfw_osc_t  osc;
        logic [1:0]  wdt_prescale;
        logic        wdt_enable;
        logic        brownout_enable;
    } cfgfw_settings_t;

    // Table read answer
    typedef struct packed {
        logic [7:0] table_latch_high;
        logic [7:0] table_latch_low;
    } cfgfw_latch_t;

endpackage : cfgfw_pkg

// >>> verilog/cfgfw_reset_timer.sv
`timescale 1ns/1ps
module cfgfw_reset_timer
    import cfgfw_pkg::*;
#(
    parameter int CYCLES = 16
)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Control
    input  wire logic start_i,
    output logic      busy_o
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    // Reload on start, count down while enabled
    always_comb
    begin
        count_next = count_reg;
        if (start_i)
            count_next = CW'(CYCLES);
        else if (count_reg != '0)
            count_next = count_reg - CW'(1);
    end

    // Loaded at reset so the hold begins immediately
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            count_reg <= CW'(CYCLES);
        else if (ce_i)
            count_reg <= count_next;
    end

    assign busy_o = (count_reg != '0);

endmodule : cfgfw_reset_timer

// >>> verilog/cfgfw_top.sv
`timescale 1ns/1ps
module cfgfw_top
    import cfgfw_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_LEN = cfgfw_pkg::POWERUP_DELAY_TIMER_CYCLES,
    parameter int OST_LEN  = cfgfw_pkg::OST_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic                       MCLK_I,
    input  wire logic                       RST_I,
    input  wire logic                       CE_I,
    // Core table port
    input  wire logic [15:0]                TBL_ADDR_I,
    input  wire logic                       TABLE_READ_INSTR_I,
    input  wire logic                       TABLE_WRITE_INSTR_I,
    output logic                            TBL_HIT_O,
    output cfgfw_pkg::cfgfw_latch_t         TBL_LATCH_O,
    // Device programmer port
    input  wire logic [15:0]                PRG_ADDR_I,
    input  wire logic                       PRG_READ_I,
    input  wire logic                       PRG_WRITE_I,
    output cfgfw_pkg::cfgfw_latch_t         PRG_LATCH_O,
    // Reset hold and sleep
    input  wire logic                       MCLR_RESET_I,
    input  wire logic                       WDT_TIMEOUT_I,
    input  wire logic                       SLEEP_ENTER_I,
    input  wire logic                       INT_PENDING_I,
    output logic                            RESET_HOLD_O,
    output logic                            SLEEP_O,
    // Decoded configuration
    output cfgfw_pkg::cfgfw_settings_t      SETTINGS_O
);
    logic [15:0]     fuse_reg;
    logic [15:0]     fuse_next;
    cfgfw_latch_t    core_latch_reg;
    cfgfw_latch_t    core_latch_next;
    cfgfw_latch_t    prg_latch_reg;
    cfgfw_latch_t    prg_latch_next;
    logic            hit_reg;
    logic            hit_next;
    logic            sleep_reg;
    logic            sleep_next;
    logic            ost_wake_reg;
    logic            ost_wake_next;
    logic            powerup_delay_timer_busy;
    logic            ost_busy;
    logic            cfg_visible;
    logic            core_in_range;
    logic            ost_start;
    cfgfw_settings_t settings;

    // Fuse address window check
    function automatic logic in_cfg(input logic [15:0] a);
        in_cfg = (a >= CFG_ADDR_BASE) && (a <= CFG_ADDR_LAST);
    endfunction : in_cfg

    // Map a location index to its word position, or none
    function automatic logic [15:0] fuse_mask(input logic [3:0] idx);
        fuse_mask = 16'h0000;
        unique case (idx)
            IDX_OSC_LO: fuse_mask[POS_OSC_LO] = 1'b1;
            IDX_OSC_HI: fuse_mask[POS_OSC_HI] = 1'b1;
            IDX_WDT_LO: fuse_mask[POS_WDT_LO] = 1'b1;
            IDX_WDT_HI: fuse_mask[POS_WDT_HI] = 1'b1;
            IDX_PM0:    fuse_mask[POS_PM0]    = 1'b1;
            IDX_PM1:    fuse_mask[POS_PM1]    = 1'b1;
            IDX_BOD:    fuse_mask[POS_BOD]    = 1'b1;
            IDX_PM2:    fuse_mask[POS_PM2]    = 1'b1;
            default:    fuse_mask = 16'h0000;
        endcase
    endfunction : fuse_mask

    // Unmapped word bits forced high on read
    function automatic cfgfw_latch_t read_word(input logic [15:0] a,
                                               input logic [15:0] f);
        logic [15:0]  impl;
        logic [15:0]  word;
        cfgfw_latch_t res;
        impl = fuse_mask(IDX_OSC_LO) | fuse_mask(IDX_OSC_HI)
             | fuse_mask(IDX_WDT_LO) | fuse_mask(IDX_WDT_HI)
             | fuse_mask(IDX_PM0) | fuse_mask(IDX_PM1)
             | fuse_mask(IDX_BOD) | fuse_mask(IDX_PM2);
        word = f | ~impl;
        res.table_latch_high = LATCH_ALL_ONES;
        if (a >= CFG_ADDR_HIGH)
            res.table_latch_low = word[15:8];
        else
            res.table_latch_low = word[7:0];
        read_word = res;
    endfunction : read_word

    // Settings decode; watchdog only steerable by fuses
    always_comb
    begin
        unique case ({fuse_reg[POS_PM2], fuse_reg[POS_PM1],
                      fuse_reg[POS_PM0]})
            PM_MICROPROC: settings.mode = CFGFW_MICROPROCESSOR;
            PM_MICROCTL:  settings.mode = CFGFW_MICROCONTROLLER;
            PM_EXTMCU:    settings.mode = CFGFW_EXT_MICROCONTROLLER;
            PM_PROTECTED: settings.mode = CFGFW_PROTECTED_MCU;
            default:      settings.mode = CFGFW_MODE_UNDEFINED;
        endcase
        settings.osc = cfgfw_osc_t'({fuse_reg[POS_OSC_HI],
                                     fuse_reg[POS_OSC_LO]});
        settings.wdt_prescale = {fuse_reg[POS_WDT_HI], fuse_reg[POS_WDT_LO]};
        settings.wdt_enable = (settings.wdt_prescale != 2'b00);
        settings.brownout_enable = fuse_reg[POS_BOD];
    end

    // Visibility to the core depends on processor mode
    assign cfg_visible = (settings.mode == CFGFW_MICROCONTROLLER)
                      || (settings.mode == CFGFW_PROTECTED_MCU);
    assign core_in_range = cfg_visible && in_cfg(TBL_ADDR_I);

    // Fuses only ever clear; data value is ignored
    always_comb
    begin
        fuse_next = fuse_reg;
        if (TABLE_WRITE_INSTR_I && core_in_range)
            fuse_next = fuse_next & ~fuse_mask(TBL_ADDR_I[3:0]);
        if (PRG_WRITE_I && in_cfg(PRG_ADDR_I))
            fuse_next = fuse_next & ~fuse_mask(PRG_ADDR_I[3:0]);
    end

    // Table latches; other addresses leave them untouched here
    always_comb
    begin
        core_latch_next = core_latch_reg;
        prg_latch_next  = prg_latch_reg;
        hit_next        = 1'b0;
        if (TABLE_READ_INSTR_I && core_in_range)
        begin
            core_latch_next = read_word(TBL_ADDR_I, fuse_reg);
            hit_next        = 1'b1;
        end
        if (PRG_READ_I && in_cfg(PRG_ADDR_I))
            prg_latch_next = read_word(PRG_ADDR_I, fuse_reg);
    end

    // Sleep: interrupt, external reset or enabled watchdog timeout ends it here
    always_comb
    begin
        sleep_next    = sleep_reg;
        ost_wake_next = 1'b0;
        if (sleep_reg && (INT_PENDING_I || MCLR_RESET_I
                          || (WDT_TIMEOUT_I && settings.wdt_enable)))
        begin
            sleep_next    = 1'b0;
            ost_wake_next = 1'b1;
        end
        else if (SLEEP_ENTER_I && !RESET_HOLD_O)
            sleep_next = 1'b1;
    end

    // Fuses model the unprogrammed state at power-on only
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            fuse_reg       <= {FUSE_RESET, FUSE_RESET};
            core_latch_reg <= '1;
            prg_latch_reg  <= '1;
            hit_reg        <= 1'b0;
            sleep_reg      <= 1'b0;
            ost_wake_reg   <= 1'b0;
        end
        else if (CE_I)
        begin
            fuse_reg       <= fuse_next;
            core_latch_reg <= core_latch_next;
            prg_latch_reg  <= prg_latch_next;
            hit_reg        <= hit_next;
            sleep_reg      <= sleep_next;
            ost_wake_reg   <= ost_wake_next;
        end
    end

    // Power-up hold runs once after power-on reset
    cfgfw_reset_timer #(.CYCLES(POWERUP_DELAY_TIMER_LEN)) u_powerup_delay_timer (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .ce_i    (CE_I),
        .start_i (1'b0),
        .busy_o  (powerup_delay_timer_busy)
    );

    // Start-up timer reruns on wake or external reset, crystal modes only
    assign ost_start = (ost_wake_reg || MCLR_RESET_I)
                    && ((settings.osc == CFGFW_CRYSTAL_RESONATOR_MODE)
                     || (settings.osc == CFGFW_LOW_POWER_CRYSTAL_MODE));

    cfgfw_reset_timer #(.CYCLES(OST_LEN)) u_ost (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .ce_i    (CE_I),
        .start_i (ost_start),
        .busy_o  (ost_busy)
    );

    // Outputs
    assign RESET_HOLD_O = powerup_delay_timer_busy || ost_busy || MCLR_RESET_I;
    assign SLEEP_O      = sleep_reg;
    assign TBL_HIT_O    = hit_reg;
    assign TBL_LATCH_O  = core_latch_reg;
    assign PRG_LATCH_O  = prg_latch_reg;
    assign SETTINGS_O   = settings;

endmodule : cfgfw_top

// >>> dv/cfgfw_props.sv
`timescale 1ns/1ps
module cfgfw_props
    import cfgfw_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_LEN = 20
)
(
    // Clock and reset
    input wire logic                   MCLK_I,
    input wire logic                   RST_I,
    input wire logic                   CE_I,
    // Table ports
    input wire logic [15:0]            TBL_ADDR_I,
    input wire logic                   TABLE_READ_INSTR_I,
    input wire logic                   TBL_HIT_O,
    input wire cfgfw_pkg::cfgfw_latch_t TBL_LATCH_O,
    input wire logic [15:0]            PRG_ADDR_I,
    input wire logic                   PRG_READ_I,
    input wire cfgfw_pkg::cfgfw_latch_t PRG_LATCH_O,
    // Settings, hold and sleep
    input wire cfgfw_pkg::cfgfw_settings_t SETTINGS_O,
    input wire logic                   RESET_HOLD_O,
    input wire logic                   SLEEP_O,
    input wire logic                   INT_PENDING_I
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    logic [15:0] up_cnt_reg;
    logic        vis;
    logic        lo_rd;
    logic        hi_rd;
    // Visible modes and programmer read ranges
    assign vis = SETTINGS_O.mode inside {CFGFW_MICROCONTROLLER,
                                         CFGFW_PROTECTED_MCU};
    assign lo_rd = CE_I && PRG_READ_I && PRG_ADDR_I[15:3] == 13'h1fc0;
    assign hi_rd = CE_I && PRG_READ_I && PRG_ADDR_I[15:3] == 13'h1fc1;
    // Cycles since reset release; saturates so it never wraps
    always_ff @(posedge MCLK_I or posedge RST_I)
        if (RST_I)
            up_cnt_reg <= 16'h0000;
        else if (CE_I && up_cnt_reg != 16'hffff)
            up_cnt_reg <= up_cnt_reg + 16'h0001;

    hit_take_a: assert property (CE_I && TABLE_READ_INSTR_I && vis
        && TBL_ADDR_I[15:4] == 12'hfe0 |=> TBL_HIT_O)
        else $error("visible core read gave no hit");
    hit_cause_a: assert property (TBL_HIT_O
        |-> $past(TABLE_READ_INSTR_I && vis)) else $error("stray hit");
    latch_ones_a: assert property (TBL_LATCH_O[15:8] == 8'hff
        && PRG_LATCH_O[15:8] == 8'hff) else $error("high latch not ones");
    unimpl_ones_a: assert property (hi_rd
        |=> PRG_LATCH_O[5:0] == 6'h3f) else $error("reserved bit low");
    osc_match_a: assert property (lo_rd |=> PRG_LATCH_O[3:0] ==
        $past({SETTINGS_O.wdt_prescale, SETTINGS_O.osc}))
        else $error("low byte disagrees with settings");
    wdt_off_a: assert property (lo_rd |=>
        (PRG_LATCH_O[3:2] != 2'h0) == $past(SETTINGS_O.wdt_enable))
        else $error("wdt enable wrong");
    fuse_oneway_a: assert property (!$rose(SETTINGS_O.wdt_prescale[0])
        && !$rose(SETTINGS_O.brownout_enable)) else $error("fuse unset");
    powerup_delay_timer_hold_a: assert property (up_cnt_reg < POWERUP_DELAY_TIMER_LEN
        |-> RESET_HOLD_O) else $error("power-up hold too short");
    sleep_wake_a: assert property (SLEEP_O && INT_PENDING_I && CE_I
        |-> ##[1:2] !SLEEP_O) else $error("no wake on interrupt");
endmodule : cfgfw_props

// >>> dv/cfgfw_partner.sv
`timescale 1ns/1ps
module cfgfw_partner
(
    // Clock
    input  wire logic   clk_i,
    // Core and programmer strobes
    output logic [15:0] tbl_addr_o,
    output logic        tbl_rd_o,
    output logic        tbl_wr_o,
    output logic [15:0] prg_addr_o,
    output logic        prg_rd_o,
    output logic        prg_wr_o
);
    initial
    begin
        tbl_addr_o = 16'h0000;
        prg_addr_o = 16'h0000;
        {tbl_rd_o, tbl_wr_o, prg_rd_o, prg_wr_o} = 4'h0;
    end
    // One table cycle; address inverted on release so no stale match
    task automatic access(input logic core, input logic wr,
                          input logic [15:0] addr);
        @(negedge clk_i);
        if (core)
        begin
            tbl_addr_o = addr;
            {tbl_rd_o, tbl_wr_o} = {!wr, wr};
        end
        else
        begin
            prg_addr_o = addr;
            {prg_rd_o, prg_wr_o} = {!wr, wr};
        end
        @(negedge clk_i);
        {tbl_rd_o, tbl_wr_o, prg_rd_o, prg_wr_o} = 4'h0;
        tbl_addr_o = ~tbl_addr_o;
        prg_addr_o = ~prg_addr_o;
    endtask : access
endmodule : cfgfw_partner

// >>> dv/config_fuse_word_access_tb.sv
`timescale 1ns/1ps
module config_fuse_word_access_tb;
    import cfgfw_pkg::*;
    localparam int PW = 20;
    localparam int OL = 8;
    // Programming steps: fuse index, path, mode expected afterwards
    localparam logic [3:0] IDX [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6,
                                       4'he, 4'hf};
    localparam logic       VIA [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
                                       1'b0, 1'b0};
    localparam cfgfw_mode_t MD [8] = '{CFGFW_MICROPROCESSOR,
        CFGFW_MICROPROCESSOR, CFGFW_MICROPROCESSOR, CFGFW_MICROPROCESSOR,
        CFGFW_MICROCONTROLLER, CFGFW_MODE_UNDEFINED, CFGFW_MODE_UNDEFINED,
        CFGFW_PROTECTED_MCU};
    logic            clk, rst, ce, mclr, slp, irq, wdt, hit, hold, asleep;
    logic [15:0]     t_addr, p_addr, word;
    logic            t_rd, t_wr, p_rd, p_wr, vis;
    cfgfw_latch_t    t_lat, p_lat;
    cfgfw_settings_t set;
    int              err_count = 0;
    int              tests_run = 0;

    cfgfw_top #(.POWERUP_DELAY_TIMER_LEN(PW), .OST_LEN(OL)) u_dut (.MCLK_I(clk),
        .RST_I(rst), .CE_I(ce), .TBL_ADDR_I(t_addr),
        .TABLE_READ_INSTR_I(t_rd), .TABLE_WRITE_INSTR_I(t_wr),
        .TBL_HIT_O(hit), .TBL_LATCH_O(t_lat), .PRG_ADDR_I(p_addr),
        .PRG_READ_I(p_rd), .PRG_WRITE_I(p_wr), .PRG_LATCH_O(p_lat),
        .MCLR_RESET_I(mclr), .WDT_TIMEOUT_I(wdt), .SLEEP_ENTER_I(slp),
        .INT_PENDING_I(irq), .RESET_HOLD_O(hold), .SLEEP_O(asleep),
        .SETTINGS_O(set));
    cfgfw_partner u_prt (.clk_i(clk), .tbl_addr_o(t_addr),
        .tbl_rd_o(t_rd), .tbl_wr_o(t_wr), .prg_addr_o(p_addr),
        .prg_rd_o(p_rd), .prg_wr_o(p_wr));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // Reads both halves of the word through the programmer port
    task automatic read_word();
        u_prt.access(1'b0, 1'b0, 16'hfe07);
        chk(p_lat, {8'hff, word[7:0]});
        u_prt.access(1'b0, 1'b0, 16'hfe08);
        chk(p_lat, {8'hff, word[15:8]});
    endtask : read_word

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Watchdog: the whole run needs well under 400 cycles
    initial
    begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial
    begin
        {rst, ce, mclr, slp, irq, wdt} = 6'b110000;
        word = 16'hffff;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        // Hold must last exactly the power-up count
        repeat (PW - 1) @(negedge clk);
        chk({15'h0, hold}, 16'h0001);
        @(negedge clk);
        chk({15'h0, hold}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            u_prt.access(VIA[i], 1'b1, 16'hfe00 | IDX[i]);
            word[IDX[i]] = 1'b0;
            read_word();
            vis = MD[i] inside {CFGFW_MICROCONTROLLER, CFGFW_PROTECTED_MCU};
            u_prt.access(1'b1, 1'b0, 16'hfe0f);
            chk({15'h0, hit}, {15'h0, vis});
            chk(16'(set), 16'({MD[i], word[1:0], word[3:2],
                |word[3:2], word[14]}));
            if (vis)
                chk(t_lat, {8'hff, word[15:8]});
        end
        // Sleep: disabled watchdog cannot wake it, an interrupt can
        slp = 1'b1;
        @(negedge clk);
        {slp, wdt} = 2'b01;
        chk({15'h0, asleep}, 16'h0001);
        @(negedge clk);
        wdt = 1'b0;
        chk({15'h0, asleep}, 16'h0001);
        irq = 1'b1;
        repeat (2) @(negedge clk);
        chk({15'h0, asleep}, 16'h0000);
        // External reset restarts the start-up hold in low-power crystal mode
        {irq, mclr} = 2'b01;
        @(negedge clk);
        mclr = 1'b0;
        chk({15'h0, hold}, 16'h0001);
        repeat (OL) @(negedge clk);
        chk({15'h0, hold}, 16'h0000);
        rst = 1'b1;
        // Second reset: part unprogrammed again, refused writes change nothing
        repeat (2) @(negedge clk);
        rst = 1'b0;
        word = 16'hffff;
        chk({15'h0, hold}, 16'h0001);
        ce = 1'b0;
        u_prt.access(1'b0, 1'b1, 16'hfe00);
        ce = 1'b1;
        u_prt.access(1'b1, 1'b1, 16'hfe01);
        u_prt.access(1'b0, 1'b1, 16'hfe05);
        u_prt.access(1'b0, 1'b1, 16'hfe10);
        read_word();
        u_prt.access(1'b0, 1'b1, 16'hfe06);
        chk(16'(set.mode), 16'(CFGFW_EXT_MICROCONTROLLER));
        u_prt.access(1'b1, 1'b0, 16'hfe00);
        chk({15'h0, hit}, 16'h0000);
        // Enabled watchdog ends sleep once the power-up hold is over
        repeat (PW) @(negedge clk);
        slp = 1'b1;
        @(negedge clk);
        {slp, wdt} = 2'b01;
        chk({15'h0, asleep}, 16'h0001);
        @(negedge clk);
        wdt = 1'b0;
        chk({15'h0, asleep}, 16'h0000);
        give_verdict();
    end
endmodule : config_fuse_word_access_tb

bind cfgfw_top cfgfw_props #(.POWERUP_DELAY_TIMER_LEN(POWERUP_DELAY_TIMER_LEN)) u_props (.MCLK_I(MCLK_I),
    .RST_I(RST_I), .CE_I(CE_I), .TBL_ADDR_I(TBL_ADDR_I),
    .TABLE_READ_INSTR_I(TABLE_READ_INSTR_I), .TBL_HIT_O(TBL_HIT_O),
    .TBL_LATCH_O(TBL_LATCH_O), .PRG_ADDR_I(PRG_ADDR_I),
    .PRG_READ_I(PRG_READ_I), .PRG_LATCH_O(PRG_LATCH_O),
    .SETTINGS_O(SETTINGS_O), .RESET_HOLD_O(RESET_HOLD_O),
    .SLEEP_O(SLEEP_O), .INT_PENDING_I(INT_PENDING_I));
